/* File: core/gpc_top.sv */
/*
 * gpc_top: control, pad gating and interrupt logic for one general
 * purpose pin, with an AXI4-Lite register slave.
 * Assumes pad_in and the rail-good levels are asynchronous pins and
 * the alternate function signals come from logic on aclk.
 */
// Functional notes
// [RULE1] buffer type bit: one selects open drain, zero push-pull.
// [RULE2] direction bit steers pad only when function select is zero.
// [RULE3] interrupt mode comes from edge enable bit and detect field.
// [RULE4] codes: low level, high level, rising, falling, either edge.
// [RULE5] edge enable zero with detect 100 gives no events.
// [RULE6] only edge detections may wake the main clock domain.
// [RULE7] wake needs edge mode and an enabled interrupt, both firmware set.
// [RULE8] standby output-only code: input off, output off when rail down.
// [RULE9] unpowered code: input, output and pulls all off.
// [RULE10] other codes pick main or standby rail; tristate when it is off.
// [RULE11] firmware picks output-only code for 1.8V open drain on 3.3V pad.
// [RULE12] pull field: keeper at 11b, pull down at 10b.
// [RULE13] drive strength field 5:4: 2, 4, 8, 12 mA.
// [RULE14] slew bit 0 resets to zero: slow; one selects fast.
// [RULE15] input register always returns the real pin level.
// [RULE16] input bits of absent pins are reserved and read zero.
// [RULE17] pull up at 01b, none at 00b; reserved bits read zero.
// [RULE18] pin synchronised before edge compare, one pulse per edge.
`default_nettype none

module gpc_top #(
    parameter bit PIN_PRESENT = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [gpc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pad_in,
    input wire logic main_rail_good,
    input wire logic standby_rail,
    input wire logic alt_out,
    input wire logic alt_oe,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_ie,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic keeper_en,
    output logic [1:0] drive_sel,
    output logic slew_fast,
    output logic irq,
    output logic wake_req
);
    typedef struct packed {
        logic [31:0] c1;
        logic [31:0] c2;
        logic stat;
        logic mask;
        logic aw_got;
        logic [gpc_pkg::ADDR_W-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic pad_out;
        logic pad_oe;
        logic pad_ie;
        logic pull_up;
        logic pull_dn;
        logic keeper;
        logic irq;
        logic wake;
    } gpc_top_st_t;

    localparam gpc_top_st_t ST_RST = '{c1: gpc_pkg::C1_RST,
                                       c2: gpc_pkg::C2_RST,
                                       default: '0};

    gpc_top_st_t q;
    gpc_top_st_t d;
    logic [2:0] sync_q;
    logic pin_s;
    logic main_s;
    logic stby_s;
    logic [31:0] bm;
    logic wr_go;
    logic clr;
    logic [1:0] well;
    logic gpio_sel;
    logic drv_en;
    logic drv_val;
    logic od;
    logic well_on;

    gpc_det_if dif ();

    // byte strobes to a bit mask
    function automatic logic [31:0] gpc_strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : gpc_strb_mask

    // only writable bits under strobe change; reserved stay zero
    function automatic logic [31:0] gpc_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction : gpc_merge

    gpc_sync #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({pad_in, main_rail_good, standby_rail}),
        .q(sync_q)
    );

    assign pin_s = sync_q[2];
    assign main_s = sync_q[1];
    assign stby_s = sync_q[0];

    // detector sees the pin even when the input pad is gated
    assign dif.det_mode = q.c1[gpc_pkg::C1_EDGE_BIT -: 4]; // RULE3
    assign dif.pin_lvl = pin_s; // RULE18

    gpc_detect u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .dif(dif.det)
    );

    // register bus, interrupt state and pad controls
    always_comb begin
        d = q;
        bm = gpc_strb_mask(q.wstrb);
        wr_go = q.aw_got && q.w_got && !q.bvalid;
        clr = 1'b0;
        if (awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        // write goes once both halves are held
        if (wr_go) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = gpc_pkg::RESP_OKAY;
            if (q.awaddr == gpc_pkg::OFF_CTRL1) begin
                d.c1 = gpc_merge(q.c1, q.wdata,
                                 bm & gpc_pkg::C1_WMASK); // RULE17
            end else if (q.awaddr == gpc_pkg::OFF_CTRL2) begin
                d.c2 = gpc_merge(q.c2, q.wdata,
                                 bm & gpc_pkg::C2_WMASK); // RULE13
            end else if (q.awaddr == gpc_pkg::OFF_STAT) begin
                clr = q.wdata[0] && bm[0];
            end else if (q.awaddr == gpc_pkg::OFF_MASK) begin
                d.mask = bm[0] ? q.wdata[0] : q.mask;
            end else if (q.awaddr == gpc_pkg::OFF_INPUT) begin
                d.bresp = gpc_pkg::RESP_OKAY; // read-only, ignored
            end else begin
                d.bresp = gpc_pkg::RESP_SLVERR;
            end
        end
        d.awready = !d.aw_got;
        d.wready = !d.w_got;

        // read answers one cycle after the address is taken
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = gpc_pkg::RESP_OKAY;
            if (araddr == gpc_pkg::OFF_CTRL1) begin
                d.rdata = q.c1;
            end else if (araddr == gpc_pkg::OFF_CTRL2) begin
                d.rdata = q.c2; // RULE14
            end else if (araddr == gpc_pkg::OFF_INPUT) begin
                // level read straight from the pin, any function
                d.rdata = {31'h0, PIN_PRESENT && pin_s}; // RULE15 RULE16
            end else if (araddr == gpc_pkg::OFF_STAT) begin
                d.rdata = {31'h0, q.stat};
            end else if (araddr == gpc_pkg::OFF_MASK) begin
                d.rdata = {31'h0, q.mask};
            end else begin
                d.rdata = 32'h0000_0000;
                d.rresp = gpc_pkg::RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;

        // set wins over a clear in the same cycle
        d.stat = (q.stat && !clr) || dif.evt;
        d.irq = d.stat && d.mask;
        // wake only from edge events that firmware enabled
        d.wake = dif.edge_evt && q.mask; // RULE6 RULE7

        // pad buffer, gated by the selected well
        well = q.c1[gpc_pkg::C1_WELL_LSB +: 2];
        od = q.c1[gpc_pkg::C1_OD_BIT];
        gpio_sel = q.c1[gpc_pkg::C1_FUNC_LSB +: 2] == 2'h0;
        drv_en = gpio_sel ? q.c1[gpc_pkg::C1_DIR_BIT] : alt_oe; // RULE2
        drv_val = gpio_sel ? q.c1[gpc_pkg::C1_DOUT_BIT] : alt_out;
        case (well) // RULE10
            gpc_pkg::WELL_MAIN: well_on = main_s;
            gpc_pkg::WELL_STBY: well_on = stby_s;
            gpc_pkg::WELL_STBY_OUT: well_on = stby_s; // RULE8
            default: well_on = 1'b0; // RULE9
        endcase
        // open drain only ever pulls low, so a high releases the pin
        d.pad_out = od ? 1'b0 : drv_val; // RULE1
        d.pad_oe = drv_en && well_on && (!od || !drv_val); // RULE1
        d.pad_ie = well_on && well != gpc_pkg::WELL_STBY_OUT; // RULE8
        d.pull_up = 1'b0;
        d.pull_dn = 1'b0;
        d.keeper = 1'b0;
        if (well != gpc_pkg::WELL_OFF) begin // RULE9
            case (q.c1[gpc_pkg::C1_PULL_LSB +: 2])
                gpc_pkg::PULL_UP: d.pull_up = 1'b1; // RULE17
                gpc_pkg::PULL_DOWN: d.pull_dn = 1'b1; // RULE12
                gpc_pkg::PULL_KEEP: d.keeper = 1'b1; // RULE12
                default: d.keeper = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign awready = q.awready;
    assign wready = q.wready;
    assign bresp = q.bresp;
    assign bvalid = q.bvalid;
    assign arready = q.arready;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign rvalid = q.rvalid;
    assign pad_out = q.pad_out;
    assign pad_oe = q.pad_oe;
    assign pad_ie = q.pad_ie;
    assign pull_up_en = q.pull_up;
    assign pull_down_en = q.pull_dn;
    assign keeper_en = q.keeper;
    assign drive_sel = q.c2[gpc_pkg::C2_DRV_LSB +: 2]; // RULE13
    assign slew_fast = q.c2[gpc_pkg::C2_SLEW_BIT]; // RULE14
    assign irq = q.irq;
    assign wake_req = q.wake;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_held;
        q.aw_got && q.w_got && !q.bvalid;
    endsequence
    sequence s_resp_done;
        bvalid ##1 (bvalid || $past(bready));
    endsequence

    a_write_resp: assert property (s_both_held |=> s_resp_done)
        else $error("write response missing");
    a_unpowered_pad: assert property ( // RULE9
        q.c1[3:2] == gpc_pkg::WELL_OFF |=> !pad_oe && !pad_ie
        && !pull_up_en && !pull_down_en && !keeper_en)
        else $error("unpowered pad not fully off");
    a_well_off_tri: assert property ( // RULE10
        q.c1[3:2] == gpc_pkg::WELL_MAIN && !main_s |=> !pad_oe)
        else $error("pin driven with main rail off");
    a_stby_out_only: assert property ( // RULE8
        q.c1[3:2] == gpc_pkg::WELL_STBY_OUT |=> !pad_ie
        && (!pad_oe || $past(stby_s)))
        else $error("input enabled in output-only mode");
    a_open_drain: assert property ( // RULE1
        q.c1[gpc_pkg::C1_OD_BIT] |=> !(pad_oe && pad_out))
        else $error("open drain drove high");
    a_gpio_dir: assert property ( // RULE2
        q.c1[13:12] == 2'h0 && !q.c1[gpc_pkg::C1_DIR_BIT] |=> !pad_oe)
        else $error("gpio input pin driven");
    a_event_sticky: assert property (
        dif.evt |=> q.stat [*1] ##0 (irq == q.mask))
        else $error("event lost or irq wrong");
    a_pull_keeper: assert property ( // RULE12
        q.c1[3:2] != gpc_pkg::WELL_OFF && q.c1[1:0] == gpc_pkg::PULL_KEEP
        |=> keeper_en && !pull_up_en && !pull_down_en)
        else $error("keeper not selected");
    a_wake_masked: assert property ( // RULE7
        wake_req |-> $past(dif.edge_evt) && $past(q.mask))
        else $error("wake without enabled edge event");

endmodule : gpc_top

`default_nettype wire

/* File: core/gpc_pkg.sv */
/*
 * gpc_pkg: register offsets, field positions, reset values and codes
 * for the single-pin control and interrupt detect block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package gpc_pkg;

    localparam int ADDR_W = 6;

    // register byte offsets
    localparam logic [5:0] OFF_CTRL1 = 6'h00;
    localparam logic [5:0] OFF_CTRL2 = 6'h04;
    localparam logic [5:0] OFF_INPUT = 6'h08;
    localparam logic [5:0] OFF_STAT = 6'h0C;
    localparam logic [5:0] OFF_MASK = 6'h10;

    // primary control fields
    localparam int C1_PULL_LSB = 0;
    localparam int C1_WELL_LSB = 2;
    localparam int C1_DET_LSB = 4;
    localparam int C1_EDGE_BIT = 7;
    localparam int C1_OD_BIT = 8;
    localparam int C1_DIR_BIT = 9;
    localparam int C1_FUNC_LSB = 12;
    localparam int C1_DOUT_BIT = 16;
    localparam logic [31:0] C1_WMASK = 32'h0001_33FF;
    localparam logic [31:0] C1_RST = 32'h0000_0040;

    // secondary control fields
    localparam int C2_SLEW_BIT = 0;
    localparam int C2_DRV_LSB = 4;
    localparam logic [31:0] C2_WMASK = 32'h0000_0031;
    localparam logic [31:0] C2_RST = 32'h0000_0000;

    // edge enable plus detection field codes
    localparam logic [3:0] DET_LOW = 4'h0;
    localparam logic [3:0] DET_HIGH = 4'h1;
    localparam logic [3:0] DET_OFF = 4'h4;
    localparam logic [3:0] DET_RISE = 4'hD;
    localparam logic [3:0] DET_FALL = 4'hE;
    localparam logic [3:0] DET_BOTH = 4'hF;

    // power well codes
    localparam logic [1:0] WELL_MAIN = 2'h0;
    localparam logic [1:0] WELL_STBY = 2'h1;
    localparam logic [1:0] WELL_OFF = 2'h2;
    localparam logic [1:0] WELL_STBY_OUT = 2'h3;

    // pull codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_UP = 2'h1;
    localparam logic [1:0] PULL_DOWN = 2'h2;
    localparam logic [1:0] PULL_KEEP = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpc_pkg

`default_nettype wire

/* File: core/gpc_det_if.sv */
/*
 * gpc_det_if: carries detection mode and synced pin level to the
 * detector and its events back. Assumes one clock, owned by users.
 */
`default_nettype none

interface gpc_det_if;
    logic [3:0] det_mode;
    logic pin_lvl;
    logic evt;
    logic edge_evt;
    modport cfg (output det_mode, output pin_lvl,
                 input evt, input edge_evt);
    modport det (input det_mode, input pin_lvl,
                 output evt, output edge_evt);
endinterface : gpc_det_if

`default_nettype wire

/* File: core/gpc_sync.sv */
/*
 * gpc_sync: two-flop synchroniser for asynchronous pin levels.
 * Assumes inputs change slowly against aclk; no pulse stretching.
 */
`default_nettype none

module gpc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule : gpc_sync

`default_nettype wire

/* File: core/gpc_detect.sv */
/*
 * gpc_detect: level and edge interrupt detection for one pin.
 * Assumes pin_lvl is already synchronised to aclk.
 */
`default_nettype none

module gpc_detect (
    input wire logic aclk,
    input wire logic aresetn,
    gpc_det_if.det dif
);
    typedef struct packed {
        logic prev;
        logic evt;
        logic edge_evt;
    } gpc_det_st_t;

    gpc_det_st_t q;
    gpc_det_st_t d;
    logic rise;
    logic fall;
    logic edge_mode;

    assign edge_mode = dif.det_mode[3];

    // compare against last sample, one pulse per transition
    always_comb begin
        d = q;
        rise = dif.pin_lvl && !q.prev; // RULE18
        fall = !dif.pin_lvl && q.prev;
        d.prev = dif.pin_lvl;
        d.evt = 1'b0;
        d.edge_evt = 1'b0;
        case (dif.det_mode) // RULE3
            gpc_pkg::DET_LOW: d.evt = !dif.pin_lvl; // RULE4
            gpc_pkg::DET_HIGH: d.evt = dif.pin_lvl;
            gpc_pkg::DET_RISE: begin
                d.evt = rise;
                d.edge_evt = rise; // RULE6
            end
            gpc_pkg::DET_FALL: begin
                d.evt = fall;
                d.edge_evt = fall;
            end
            gpc_pkg::DET_BOTH: begin
                d.evt = rise || fall;
                d.edge_evt = rise || fall;
            end
            // disabled code and reserved codes stay silent
            default: d.evt = 1'b0; // RULE5
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dif.evt = q.evt;
    assign dif.edge_evt = q.edge_evt;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rise_event: assert property ( // RULE4
        dif.det_mode == gpc_pkg::DET_RISE && $rose(dif.pin_lvl)
        |=> dif.evt && dif.edge_evt)
        else $error("rising edge missed");
    a_off_silent: assert property ( // RULE5
        dif.det_mode == gpc_pkg::DET_OFF |=> !dif.evt)
        else $error("event while detection disabled");
    a_level_low: assert property ( // RULE3
        dif.det_mode == gpc_pkg::DET_LOW && !dif.pin_lvl |=> dif.evt)
        else $error("low level not reported");
    a_wake_edge_only: assert property ( // RULE6
        dif.edge_evt |-> $past(edge_mode))
        else $error("edge event outside edge mode");

endmodule : gpc_detect

`default_nettype wire

/* File: verification/gpc_board.sv */
/*
 * gpc_board: board side of one pin: an external driver, the two rail
 * levels and the resolved wire level fed back as pad_in.
 * Assumes pad controls come from gpc_top and knobs from the bench.
 */
`default_nettype none

module gpc_board (
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic keeper_en,
    input wire logic ext_en,
    input wire logic ext_val,
    input wire logic main_on,
    input wire logic stby_on,
    output logic pad_in,
    output logic main_rail_good,
    output logic standby_rail
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    logic drv;

    // chip driver wins; a released wire shows the last driven level only when the keeper is on
    assign drv = pad_oe ? pad_out : ext_val;
    assign pad_in = (pad_oe | ext_en) ? drv : pull_up_en ? 1'b1 :
                    pull_down_en ? 1'b0 : keeper_en ? last : ~last;
    assign main_rail_good = main_on;
    assign standby_rail = stby_on;

    // remember the last driven level for keeper and float pattern
    always @* begin
        if (pad_oe | ext_en) last = drv;
    end
endmodule : gpc_board

`default_nettype wire

/* File: verification/tb.sv */
/*
 * tb: register-level bench for gpc_top over AXI4-Lite with a board
 * model on the pin. Assumes the design's package and modules compile first.
 */
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0;
    logic [5:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, drive_sel;
    logic [31:0] rdata;
    logic pad_in, main_rail_good, standby_rail, pad_out, pad_oe, pad_ie;
    logic pull_up_en, pull_down_en, keeper_en, slew_fast, irq, wake_req;
    logic alt_out = 0, alt_oe = 0, ext_en = 1, ext_val = 0;
    logic main_on = 1, stby_on = 1;
    int bad_count = 0, n_tests = 0, wake_cnt = 0, k, w0;
    logic [3:0] md [3] = '{gpc_pkg::DET_RISE, gpc_pkg::DET_FALL,
                           gpc_pkg::DET_BOTH};

    gpc_top u_gpc_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pad_in(pad_in),
        .main_rail_good(main_rail_good), .standby_rail(standby_rail),
        .alt_out(alt_out), .alt_oe(alt_oe), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_ie(pad_ie), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .keeper_en(keeper_en),
        .drive_sel(drive_sel), .slew_fast(slew_fast), .irq(irq),
        .wake_req(wake_req));
    gpc_board u_gpc_board (.pad_out(pad_out), .pad_oe(pad_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .keeper_en(keeper_en), .ext_en(ext_en), .ext_val(ext_val),
        .main_on(main_on), .stby_on(stby_on), .pad_in(pad_in),
        .main_rail_good(main_rail_good), .standby_rail(standby_rail));

    initial begin
        forever #10 aclk = ~aclk;
    end

    // count one-cycle wake pulses
    always @(posedge aclk) begin
        if (wake_req === 1'b1) wake_cnt++;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic tmo(input int i);
        if (i >= 200) begin
            bad_count++;
            $display("FAIL %0t bus wait ran out", $time);
            close_out();
        end
    endtask : tmo

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int i;
        logic ad, wd;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 0;
        wd = 0;
        for (i = 0; i < 200 && !(ad && wd); i++) begin
            @(posedge aclk);
            if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
            if (!wd && wready) begin wd = 1; wvalid <= 1'b0; end
        end
        tmo(i);
        for (i = 0; i < 200 && !(bvalid === 1'b1); i++) @(posedge aclk);
        tmo(i);
        `CHK(bresp, er)
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge aclk);
            if (arready) break;
        end
        tmo(i);
        arvalid <= 1'b0;
        for (i = 0; i < 200 && !(rvalid === 1'b1); i++) @(posedge aclk);
        tmo(i);
        `CHK(rdata, e)
        `CHK(rresp, er)
        rready <= 1'b0;
    endtask : rd

    function automatic logic [31:0] c1(logic dout, logic [1:0] fn,
        logic dir, logic od, logic [3:0] det, logic [1:0] wl,
        logic [1:0] pl);
        return {15'h0, dout, 2'h0, fn, 2'h0, dir, od, det, wl, pl};
    endfunction : c1

    // main sequence; each step waits out the two-flop pin/rail latency
    initial begin
        cyc(10);
        aresetn <= 1'b1;
        rd(gpc_pkg::OFF_CTRL1, gpc_pkg::C1_RST, gpc_pkg::RESP_OKAY);
        rd(gpc_pkg::OFF_CTRL2, 32'h0, gpc_pkg::RESP_OKAY);
        rd(gpc_pkg::OFF_MASK, 32'h0, gpc_pkg::RESP_OKAY);
        rd(6'h14, 32'h0, gpc_pkg::RESP_SLVERR);
        wr(6'h14, 32'hFFFF_FFFF, gpc_pkg::RESP_SLVERR);
        wr(gpc_pkg::OFF_CTRL2, 32'hFFFF_FFFF, gpc_pkg::RESP_OKAY);
        rd(gpc_pkg::OFF_CTRL2, 32'h0000_0031, gpc_pkg::RESP_OKAY);
        cyc(2);
        `CHK({drive_sel, slew_fast}, 3'h7)
        wr(gpc_pkg::OFF_CTRL2, 32'h0000_0020, gpc_pkg::RESP_OKAY);
        cyc(2);
        `CHK({drive_sel, slew_fast}, 3'h4)
        $display("registers done");
        // pull codes, then unpowered code overriding pull-up
        for (k = 0; k < 4; k++) begin
            wr(0, c1(0, 0, 0, 0, 4'h4, 2'h0, k[1:0]), 0);
            cyc(2);
            `CHK({pull_up_en, pull_down_en, keeper_en},
                 {k == 1, k == 2, k == 3})
        end
        wr(0, c1(1, 0, 1, 0, 4'h4, gpc_pkg::WELL_OFF, 2'h1), 0);
        cyc(2);
        `CHK({pad_ie, pad_oe, pull_up_en}, 3'h0)
        $display("pulls done");
        // push-pull out on main well, then main rail down
        wr(0, c1(1, 0, 1, 0, 4'h4, gpc_pkg::WELL_MAIN, 2'h0), 0);
        cyc(2);
        `CHK({pad_oe, pad_out, pad_ie}, 3'h7)
        main_on <= 1'b0;
        cyc(5);
        `CHK(pad_oe, 1'b0)
        // standby well ignores the main rail, follows its own
        wr(0, c1(1, 0, 1, 0, 4'h4, gpc_pkg::WELL_STBY, 2'h0), 0);
        cyc(5);
        `CHK({pad_oe, pad_ie}, 2'h3)
        stby_on <= 1'b0;
        cyc(5);
        `CHK({pad_oe, pad_ie}, 2'h0)
        stby_on <= 1'b1;
        main_on <= 1'b1;
        // output-only standby code with open drain, as firmware must use
        ext_en <= 1'b0;
        wr(0, c1(1, 0, 1, 1, 4'h4, gpc_pkg::WELL_STBY_OUT, 2'h1), 0);
        cyc(5);
        `CHK({pad_oe, pad_out, pad_ie}, 3'h0)
        wr(0, c1(0, 0, 1, 1, 4'h4, gpc_pkg::WELL_STBY_OUT, 2'h1), 0);
        cyc(2);
        `CHK({pad_oe, pad_out}, 2'h2)
        stby_on <= 1'b0;
        cyc(5);
        `CHK({pad_oe, pad_ie}, 2'h0)
        stby_on <= 1'b1;
        $display("pad gating done");
        // alternate function owns direction; input still readable
        alt_oe <= 1'b1;
        alt_out <= 1'b1;
        wr(0, c1(0, 2'h1, 0, 0, 4'h4, gpc_pkg::WELL_MAIN, 2'h0), 0);
        cyc(5);
        `CHK({pad_oe, pad_out}, 2'h3)
        rd(gpc_pkg::OFF_INPUT, 32'h1, 0);
        alt_oe <= 1'b0;
        ext_en <= 1'b1;
        wr(0, c1(0, 2'h1, 1, 0, 4'h4, gpc_pkg::WELL_MAIN, 2'h0), 0);
        cyc(5);
        `CHK(pad_oe, 1'b0)
        rd(gpc_pkg::OFF_INPUT, 32'h0, 0);
        $display("function select done");
        // edge modes: one status and one wake per qualifying transition
        wr(gpc_pkg::OFF_MASK, 32'h1, 0);
        for (k = 0; k < 3; k++) begin
            wr(0, c1(0, 0, 0, 0, md[k], 0, 0), 0);
            wr(gpc_pkg::OFF_STAT, 32'h1, 0);
            w0 = wake_cnt;
            ext_val <= 1'b1;
            cyc(8);
            `CHK(irq, k != 1)
            rd(gpc_pkg::OFF_STAT, {31'h0, k != 1}, 0);
            wr(gpc_pkg::OFF_STAT, 32'h1, 0);
            ext_val <= 1'b0;
            cyc(8);
            rd(gpc_pkg::OFF_STAT, {31'h0, k != 0}, 0);
            `CHK(wake_cnt - w0, (k == 2) ? 2 : 1)
        end
        $display("edge modes done");
        // level modes raise status but never wake
        w0 = wake_cnt;
        // mode first, so the rising pin never meets the old edge mode
        wr(0, c1(0, 0, 0, 0, gpc_pkg::DET_HIGH, 0, 0), 0);
        ext_val <= 1'b1;
        cyc(8);
        `CHK(irq, 1'b1)
        wr(gpc_pkg::OFF_MASK, 32'h0, 0);
        cyc(2);
        `CHK(irq, 1'b0)
        ext_val <= 1'b0;
        wr(0, c1(0, 0, 0, 0, gpc_pkg::DET_LOW, 0, 0), 0);
        wr(gpc_pkg::OFF_STAT, 32'h1, 0);
        cyc(8);
        rd(gpc_pkg::OFF_STAT, 32'h1, 0);
        `CHK(wake_cnt - w0, 0)
        // disabled and reserved codes: no events at either level
        wr(gpc_pkg::OFF_MASK, 32'h1, 0);
        for (k = 0; k < 2; k++) begin
            wr(0, c1(0, 0, 0, 0, k ? 4'h2 : gpc_pkg::DET_OFF, 0, 0), 0);
            wr(gpc_pkg::OFF_STAT, 32'h1, 0);
            ext_val <= 1'b1;
            cyc(8);
            ext_val <= 1'b0;
            cyc(8);
            rd(gpc_pkg::OFF_STAT, 32'h0, 0);
            `CHK(irq, 1'b0)
        end
        $display("level and disabled modes done");
        close_out();
    end
endmodule : tb

`default_nettype wire
